/* shared/jtag_seq_defs.vh */
// Purpose: constants for the boundary-scan configuration sequencer
// Assumes: 250 MHz system clock, test clock made by a divider
// Notes: tap state codes follow the usual 4-bit numbering
`ifndef JTAG_SEQ_DEFS_VH
`define JTAG_SEQ_DEFS_VH

// ==========================================================
// tap controller states
`define TAP_RESET      4'h0
`define TAP_IDLE       4'h1
`define TAP_DR_SELECT  4'h2
`define TAP_DR_CAPTURE 4'h3
`define TAP_DR_SHIFT   4'h4
`define TAP_DR_EXIT1   4'h5
`define TAP_DR_PAUSE   4'h6
`define TAP_DR_EXIT2   4'h7
`define TAP_DR_UPDATE  4'h8
`define TAP_IR_SELECT  4'h9
`define TAP_IR_CAPTURE 4'ha
`define TAP_IR_SHIFT   4'hb
`define TAP_IR_EXIT1   4'hc
`define TAP_IR_PAUSE   4'hd
`define TAP_IR_EXIT2   4'he
`define TAP_IR_UPDATE  4'hf

// ==========================================================
// command codes
`define CMD_RESET  2'h0
`define CMD_IRSCAN 2'h1
`define CMD_DRSCAN 2'h2
`define CMD_WAIT   2'h3

// ==========================================================
// widths and timing
`define DATA_W       32
`define LEN_W        6
`define FIFO_DEPTH   4
`define SYS_CLK_MHZ  250
`define TCK_PERIOD_NS 80
`define TCK_HALF_CYC (`TCK_PERIOD_NS * `SYS_CLK_MHZ / 2000)
`define RESET_TMS_ONES 5

`endif

/* design/jtag_fifo.v */
// Purpose: small word buffer between the command source and the sequencer
// Assumes: one clock, synchronous reset
// Notes: read data come out of a register
`timescale 1ns/1ps
`default_nettype none
module jtag_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire [AW:0] count = wr_ptr - rd_ptr;
  // the output register counts as one of the DEPTH slots, so a full
  // buffer holds exactly DEPTH words and not one more
  wire [AW+1:0] held = {1'b0, count} + {{(AW+1){1'b0}}, out_valid};
  wire mem_empty = (count == {(AW+1){1'b0}});
  wire pop = !mem_empty && (!out_valid || out_ready);
  assign in_ready = (held < DEPTH[AW+1:0]);

  always @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rd_ptr[AW-1:0]];
        rd_ptr <= rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule // jtag_fifo
`default_nettype wire

/* design/tck_divider.v */
// Purpose: makes the half-period enable for the test clock
// Assumes: HALF cycles of clk per test clock half period
// Notes: runs free; tick is one cycle wide
`timescale 1ns/1ps
`default_nettype none
module tck_divider #(
  parameter HALF = 10
) (
  input wire clk,
  input wire rst,
  output reg tick
);
  reg [7:0] cnt;
  always @(posedge clk) begin
    if (rst) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else if (cnt == HALF[7:0] - 8'h01) begin
      cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule // tck_divider
`default_nettype wire

/* design/jtag_config_chain_sequencer.v */
// Purpose: host-side player of reset, instruction scan, data scan, wait
// Assumes: test clock made here by divider; chain pins sampled twice
// Notes: command word = {cmd[1:0], len[5:0], data/cycles[31:0]}
`timescale 1ns/1ps
`default_nettype none
`include "jtag_seq_defs.vh"

// Contract
// RULE1 - host holds every chain-enable input low throughout jtag configuration
// RULE2 - first chain-enable grounded, each output feeds next, last open
// RULE3 - device drops chain-enable output low after it finishes configuring
// RULE4 - shared chains: enables grounded or configure in chain order
// RULE5 - successful jtag configuration drives chain-enable output low
// RULE6 - host checks config-complete flag after load, reports pass or fail
// RULE7 - never start jtag configuration during another configuration mode
// RULE8 - tap is sixteen states, stepping on rising test clock by mode-select
// RULE9 - instruction load steers tap to shift-ir, shifts bits on data-in
// RULE10 - after instruction scan go to idle and hold for latch delay
// RULE11 - data scan uses same sequence along the data branch
// RULE12 - each command yields needed test clock, mode-select, data-in waves
// RULE13 - wait command holds tap in idle for given period
// RULE14 - scans repeat as commanded until every device is programmed
// RULE15 - vector stored lsb first, scan field sent msb down to lsb; the code shifts shreg[0] out first, lsb up to msb
// RULE16 - bridge exposes chain at one bus address for reads and writes
// RULE17 - direct drive uses four pins: clock, mode-select, data-in, data-out
// RULE18 - data-in sampled on rising edge, data-out changes on falling edge
// RULE19 - device pulls error low on failure, releases complete flag on success
// RULE20 - bypass device delays data by one test clock
// RULE21 - active-low test reset asynchronously resets tap
// RULE22 - standard state graph; five high mode-selects reach reset
// RULE23 - host tracks tap state to know the needed mode-select path
module jtag_config_chain_sequencer (
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [39:0] cmd_data, // [RULE16]
  input wire other_config_busy,
  output reg rsp_valid,
  output reg [31:0] rsp_data,
  output reg busy,
  output reg config_ok,
  output reg config_fail,
  output reg tck, // [RULE17]
  output reg tms,
  output reg tdi,
  input wire tdo,
  output reg trst_n,
  output reg chain_enable_in_n,
  input wire config_complete_flag,
  input wire config_error_status_n
);
  // ========================================================
  // command buffer and divider
  wire q_valid;
  reg q_ready;
  wire [39:0] q_data;
  wire tick;

  jtag_fifo #(.WIDTH(40), .DEPTH(`FIFO_DEPTH), .AW(2)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd_data),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  tck_divider #(.HALF(`TCK_HALF_CYC)) u_div (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // ========================================================
  // pin synchronisers
  reg [1:0] tdo_s;
  reg [1:0] done_s;
  reg [1:0] err_s;
  reg [1:0] busy_s;
  always @(posedge clk) begin
    if (rst) begin
      tdo_s <= 2'b00;
      done_s <= 2'b00;
      err_s <= 2'b11;
      busy_s <= 2'b00;
    end else begin
      tdo_s <= {tdo_s[0], tdo};
      done_s <= {done_s[0], config_complete_flag};
      err_s <= {err_s[0], config_error_status_n};
      busy_s <= {busy_s[0], other_config_busy};
    end
  end

  // ========================================================
  // tap state graph, tracked by the host
  function [3:0] tap_next;
    input [3:0] s;
    input m;
    begin
      case (s)
        `TAP_RESET: tap_next = m ? `TAP_RESET : `TAP_IDLE;
        `TAP_IDLE: tap_next = m ? `TAP_DR_SELECT : `TAP_IDLE;
        `TAP_DR_SELECT: tap_next = m ? `TAP_IR_SELECT : `TAP_DR_CAPTURE;
        `TAP_DR_CAPTURE: tap_next = m ? `TAP_DR_EXIT1 : `TAP_DR_SHIFT;
        `TAP_DR_SHIFT: tap_next = m ? `TAP_DR_EXIT1 : `TAP_DR_SHIFT;
        `TAP_DR_EXIT1: tap_next = m ? `TAP_DR_UPDATE : `TAP_DR_PAUSE;
        `TAP_DR_PAUSE: tap_next = m ? `TAP_DR_EXIT2 : `TAP_DR_PAUSE;
        `TAP_DR_EXIT2: tap_next = m ? `TAP_DR_UPDATE : `TAP_DR_SHIFT;
        `TAP_DR_UPDATE: tap_next = m ? `TAP_DR_SELECT : `TAP_IDLE;
        `TAP_IR_SELECT: tap_next = m ? `TAP_RESET : `TAP_IR_CAPTURE;
        `TAP_IR_CAPTURE: tap_next = m ? `TAP_IR_EXIT1 : `TAP_IR_SHIFT;
        `TAP_IR_SHIFT: tap_next = m ? `TAP_IR_EXIT1 : `TAP_IR_SHIFT;
        `TAP_IR_EXIT1: tap_next = m ? `TAP_IR_UPDATE : `TAP_IR_PAUSE;
        `TAP_IR_PAUSE: tap_next = m ? `TAP_IR_EXIT2 : `TAP_IR_PAUSE;
        `TAP_IR_EXIT2: tap_next = m ? `TAP_IR_UPDATE : `TAP_IR_SHIFT;
        default: tap_next = m ? `TAP_DR_SELECT : `TAP_IDLE;
      endcase
    end
  endfunction

  // ========================================================
  // sequencer
  localparam ST_IDLE = 3'h0;
  localparam ST_RESET = 3'h1;
  localparam ST_NAV = 3'h2;
  localparam ST_SHIFT = 3'h3;
  localparam ST_EXIT = 3'h4;
  localparam ST_WAIT = 3'h5;
  localparam ST_CHECK = 3'h6;

  reg [2:0] st;
  reg [3:0] tap;
  reg [1:0] cmd;
  reg [5:0] bits_left;
  reg [31:0] shreg;
  reg [31:0] capture;
  reg [31:0] wait_cnt;
  reg [2:0] ones_cnt;
  reg phase;

  // mode-select wanted from the current tap state toward the goal
  function nav_tms;
    input [3:0] s;
    input [1:0] c;
    begin
      case (s)
        `TAP_RESET: nav_tms = 1'b0;
        `TAP_IDLE: nav_tms = 1'b1;
        `TAP_DR_SELECT: nav_tms = (c == `CMD_IRSCAN);
        `TAP_IR_SELECT: nav_tms = 1'b0;
        `TAP_DR_CAPTURE: nav_tms = 1'b0;
        `TAP_IR_CAPTURE: nav_tms = 1'b0;
        default: nav_tms = 1'b1;
      endcase
    end
  endfunction

  wire shift_state = (tap == `TAP_DR_SHIFT) || (tap == `TAP_IR_SHIFT);

  always @(posedge clk) begin
    if (rst) begin
      st <= ST_IDLE;
      tap <= `TAP_RESET;
      cmd <= `CMD_RESET;
      bits_left <= 6'h00;
      shreg <= 32'h0000_0000;
      capture <= 32'h0000_0000;
      wait_cnt <= 32'h0000_0000;
      ones_cnt <= 3'h0;
      phase <= 1'b0;
      q_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 32'h0000_0000;
      busy <= 1'b0;
      config_ok <= 1'b0;
      config_fail <= 1'b0;
      tck <= 1'b0;
      tms <= 1'b1;
      tdi <= 1'b0;
      trst_n <= 1'b1;
      chain_enable_in_n <= 1'b0; // [RULE1] [RULE2] [RULE4]
    end else begin
      q_ready <= 1'b0;
      rsp_valid <= 1'b0;
      case (st)
        ST_IDLE: begin
          busy <= 1'b0;
          // no new command starts while the synchronised busy shows another configuration mode active
          if (q_valid && !q_ready && !busy_s[1]) begin // [RULE7]
            q_ready <= 1'b1;
            busy <= 1'b1;
            cmd <= q_data[39:38];
            bits_left <= q_data[37:32];
            shreg <= q_data[31:0];
            wait_cnt <= q_data[31:0];
            capture <= 32'h0000_0000;
            ones_cnt <= 3'h0;
            phase <= 1'b0;
            if (q_data[39:38] == `CMD_RESET) begin
              st <= ST_RESET;
            end else if (q_data[39:38] == `CMD_WAIT) begin
              st <= ST_WAIT;
            end else begin
              st <= ST_NAV; // [RULE12] [RULE14]
            end
          end
        end
        default: begin
          if (tick) begin
            phase <= ~phase;
            if (!phase) begin
              // falling half: set up mode-select and data-in
              tck <= 1'b0; // [RULE18]
              case (st)
                ST_RESET: tms <= 1'b1;
                ST_NAV: tms <= nav_tms(tap, cmd); // [RULE23]
                ST_SHIFT: begin
                  tms <= (bits_left == 6'h01);
                  tdi <= shreg[0]; // [RULE15]
                end
                ST_EXIT: tms <= (tap != `TAP_DR_UPDATE) &&
                                (tap != `TAP_IR_UPDATE) &&
                                (tap != `TAP_IDLE);
                default: tms <= 1'b0; // [RULE13]
              endcase
            end else begin
              // rising half: tap advances, device samples data-in
              tck <= 1'b1;
              tap <= tap_next(tap, tms); // [RULE8] [RULE22]
              case (st)
                ST_RESET: begin
                  ones_cnt <= ones_cnt + 3'h1;
                  if (ones_cnt == `RESET_TMS_ONES - 1) begin // [RULE22]
                    st <= ST_CHECK;
                  end
                end
                ST_NAV: begin
                  if (tap_next(tap, tms) == `TAP_DR_SHIFT ||
                      tap_next(tap, tms) == `TAP_IR_SHIFT) begin
                    st <= (bits_left == 6'h00) ? ST_EXIT : ST_SHIFT; // [RULE9] [RULE11]
                  end
                end
                ST_SHIFT: begin
                  if (shift_state) begin
                    // data-out changed on the falling edge, stable here
                    capture <= {tdo_s[1], capture[31:1]}; // [RULE18]
                    shreg <= {1'b0, shreg[31:1]};
                    bits_left <= bits_left - 6'h01;
                    if (bits_left == 6'h01) begin
                      st <= ST_EXIT;
                    end
                  end
                end
                ST_EXIT: begin
                  if (tap_next(tap, tms) == `TAP_IDLE) begin
                    st <= ST_WAIT; // [RULE10]
                    wait_cnt <= 32'h0000_0001;
                  end
                end
                ST_WAIT: begin
                  if (wait_cnt <= 32'h0000_0001) begin
                    st <= ST_CHECK; // [RULE13]
                  end else begin
                    wait_cnt <= wait_cnt - 32'h0000_0001;
                  end
                end
                default: begin
                  st <= ST_CHECK;
                end
              endcase
            end
          end
          // report on the next falling half so the test clock rests low
          // between commands instead of parking high for an open time
          if (st == ST_CHECK && tick) begin
            // capture holds last bit in bit 31; align short scans down
            rsp_valid <= 1'b1;
            rsp_data <= capture >> (6'd32 - q_len_of(cmd, bits_left));
            config_ok <= done_s[1] && err_s[1]; // [RULE6] [RULE19]
            config_fail <= !done_s[1] || !err_s[1]; // [RULE6]
            st <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // scan length kept for response alignment
  reg [5:0] scan_len;
  always @(posedge clk) begin
    if (rst) begin
      scan_len <= 6'h00;
    end else if (q_ready) begin
      scan_len <= bits_left;
    end
  end

  function [5:0] q_len_of;
    input [1:0] c;
    input [5:0] unused_left;
    begin
      if ((c == `CMD_IRSCAN || c == `CMD_DRSCAN) && scan_len != 6'h00) begin
        q_len_of = scan_len;
      end else begin
        q_len_of = 6'd32;
      end
    end
  endfunction
endmodule // jtag_config_chain_sequencer
`default_nettype wire

/* verification/seq_checker_asserts.sv */
// Purpose: port checks for the config chain sequencer
// Assumes: test clock half period of ten system clocks
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module seq_checker (
  input wire clk,
  input wire rst,
  input wire other_config_busy,
  input wire busy,
  input wire rsp_valid,
  input wire config_ok,
  input wire config_fail,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  input wire chain_enable_in_n
);
  // ==========================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_enable_held_low: assert property (chain_enable_in_n == 1'b0)
    else $error("chain enable left high");
  a_test_reset_idle: assert property (trst_n == 1'b1)
    else $error("test reset asserted");
  // five cycles covers the pin synchroniser before a pop decision
  a_hold_off_busy: assert property ((other_config_busy && !busy)[*5] |=> !busy)
    else $error("command started during other configuration");
  a_tms_on_fall: assert property ($changed(tms) |-> !tck)
    else $error("mode select moved while test clock high");
  a_tdi_on_fall: assert property ($changed(tdi) |-> !tck)
    else $error("data in moved while test clock high");
  a_tck_high_len: assert property ($rose(tck) |-> ##9 tck ##1 !tck)
    else $error("test clock high phase wrong length");
  a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
    else $error("response pulse too long");
  a_verdict_apart: assert property (!(config_ok && config_fail))
    else $error("both verdicts set");
  a_verdict_at_rsp: assert property (
    ($changed(config_ok) || $changed(config_fail)) |-> rsp_valid)
    else $error("verdict moved without response");
  c_ok: cover property (rsp_valid && config_ok);
  c_fail: cover property (rsp_valid && config_fail);
  c_start: cover property ($rose(busy));
endmodule // seq_checker
bind jtag_config_chain_sequencer seq_checker chk_i (.clk(clk), .rst(rst),
  .other_config_busy(other_config_busy), .busy(busy), .rsp_valid(rsp_valid),
  .config_ok(config_ok), .config_fail(config_fail), .tck(tck), .tms(tms),
  .tdi(tdi), .trst_n(trst_n), .chain_enable_in_n(chain_enable_in_n));
`default_nettype wire

/* verification/tap_device_model.sv */
// Purpose: behavioural device on the test access port
// Assumes: one device, data register always the one-bit bypass
// Notes: fault makes the next data update report an error
`timescale 1ns/1ps
`default_nettype none
`include "jtag_seq_defs.vh"
module tap_device_model (
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic fault,
  output logic tdo,
  output logic config_complete_flag,
  output logic config_error_status_n,
  output logic chain_enable_out_n
);
  logic [3:0] state = `TAP_RESET;
  logic [9:0] ir_sh = 10'h000;
  logic [9:0] ir = 10'h000;
  logic byp = 1'b0;
  logic done = 1'b0;
  logic err = 1'b0;
  // ==========================================================
  // controller
  function automatic [3:0] nxt(input [3:0] s, input m);
    case (s)
      `TAP_RESET: nxt = m ? `TAP_RESET : `TAP_IDLE;
      `TAP_IDLE: nxt = m ? `TAP_DR_SELECT : `TAP_IDLE;
      `TAP_DR_SELECT: nxt = m ? `TAP_IR_SELECT : `TAP_DR_CAPTURE;
      `TAP_DR_CAPTURE, `TAP_DR_SHIFT: nxt = m ? `TAP_DR_EXIT1 : `TAP_DR_SHIFT;
      `TAP_DR_EXIT1: nxt = m ? `TAP_DR_UPDATE : `TAP_DR_PAUSE;
      `TAP_DR_PAUSE: nxt = m ? `TAP_DR_EXIT2 : `TAP_DR_PAUSE;
      `TAP_DR_EXIT2: nxt = m ? `TAP_DR_UPDATE : `TAP_DR_SHIFT;
      `TAP_IR_SELECT: nxt = m ? `TAP_RESET : `TAP_IR_CAPTURE;
      `TAP_IR_CAPTURE, `TAP_IR_SHIFT: nxt = m ? `TAP_IR_EXIT1 : `TAP_IR_SHIFT;
      `TAP_IR_EXIT1: nxt = m ? `TAP_IR_UPDATE : `TAP_IR_PAUSE;
      `TAP_IR_PAUSE: nxt = m ? `TAP_IR_EXIT2 : `TAP_IR_PAUSE;
      `TAP_IR_EXIT2: nxt = m ? `TAP_IR_UPDATE : `TAP_IR_SHIFT;
      default: nxt = m ? `TAP_DR_SELECT : `TAP_IDLE;
    endcase
  endfunction
  always @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state <= `TAP_RESET;
    end else begin
      state <= nxt(state, tms);
      case (state)
        `TAP_RESET: begin
          done <= 1'b0;
          err <= 1'b0;
        end
        `TAP_IR_CAPTURE: ir_sh <= 10'h001;
        `TAP_IR_SHIFT: ir_sh <= {tdi, ir_sh[9:1]};
        `TAP_IR_UPDATE: ir <= ir_sh;
        `TAP_DR_CAPTURE: byp <= 1'b0;
        `TAP_DR_SHIFT: byp <= tdi;
        `TAP_DR_UPDATE: if (fault) err <= 1'b1; else done <= 1'b1;
        default: ;
      endcase
    end
  end
  // outside a shift the line is undriven, so it wanders rather than holds
  always @(negedge tck) begin
    if (state == `TAP_IR_SHIFT) tdo <= ir_sh[0];
    else if (state == `TAP_DR_SHIFT) tdo <= byp;
    else tdo <= ~tdo;
  end
  initial tdo = 1'b0;
  assign config_complete_flag = done;
  assign config_error_status_n = !err;
  assign chain_enable_out_n = !done;
endmodule // tap_device_model
`default_nettype wire

/* verification/jtag_config_chain_sequencer_bench.sv */
// Purpose: self-checking bench for the config chain sequencer
// Assumes: device model on the far side, inputs driven at falling edge
// Notes: bypass capture puts a zero ahead of the shifted payload
`timescale 1ns/1ps
`default_nettype none
`include "jtag_seq_defs.vh"
module jtag_config_chain_sequencer_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [39:0] cmd_data = 40'h0;
  logic other_config_busy = 1'b0;
  logic fault = 1'b0;
  wire cmd_ready, rsp_valid, busy, config_ok, config_fail, tck, tms, tdi;
  wire tdo, trst_n, chain_enable_in_n, done_flag, err_n, ceo_n;
  wire [31:0] rsp_data;
  int errors = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  jtag_config_chain_sequencer uut (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
    .other_config_busy(other_config_busy), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .busy(busy), .config_ok(config_ok),
    .config_fail(config_fail), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .trst_n(trst_n), .chain_enable_in_n(chain_enable_in_n),
    .config_complete_flag(done_flag), .config_error_status_n(err_n));
  tap_device_model dev (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .fault(fault), .tdo(tdo), .config_complete_flag(done_flag),
    .config_error_status_n(err_n), .chain_enable_out_n(ceo_n));
  // ==========================================================
  // helpers
  task wrap_up;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task push(input [1:0] c, input [5:0] n, input [31:0] p);
    int i;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_data = {c, n, p};
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(negedge clk);
    if (i == 200) begin
      errors++;
      wrap_up;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task wait_rsp;
    int i;
    @(negedge clk);
    for (i = 0; i < 5000 && rsp_valid !== 1'b1; i++) @(negedge clk);
    if (i == 5000) begin
      errors++;
      wrap_up;
    end
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    push(`CMD_RESET, 6'h00, 32'h0);
    wait_rsp;
    chk(dev.state, `TAP_RESET, "state after reset");
  endtask
  task t_ir;
    push(`CMD_IRSCAN, 6'h0a, 32'h0000_0259);
    wait_rsp;
    chk(rsp_data & 32'h3ff, 32'h1, "ir capture");
    chk(dev.ir, 32'h259, "ir loaded");
    chk(dev.state, `TAP_IDLE, "idle after ir");
  endtask
  // queue held off by the other configuration, then drained with a fault
  task t_fill;
    logic [31:0] pv [4];
    int lv [4];
    logic [31:0] m;
    int i;
    pv = '{32'hf0f0_1234, 32'h0000_0001, 32'h0000_0055, 32'h8000_0001};
    lv = '{32, 1, 7, 32};
    fault = 1'b1;
    other_config_busy = 1'b1;
    repeat (8) @(negedge clk);
    for (i = 0; i < 4; i++) push(`CMD_DRSCAN, 6'(lv[i]), pv[i]);
    chk(cmd_ready, 0, "queue full refuses");
    chk(busy, 0, "held off");
    other_config_busy = 1'b0;
    for (i = 0; i < 4; i++) begin
      wait_rsp;
      m = (lv[i] == 32) ? 32'hffff_ffff : (32'h1 << lv[i]) - 32'h1;
      chk(rsp_data & m, {pv[i][30:0], 1'b0} & m, "bypass data");
    end
    chk({config_ok, config_fail}, 32'h1, "fail verdict");
    chk(ceo_n, 1, "next device held off");
  endtask
  task t_ok;
    fault = 1'b0;
    push(`CMD_RESET, 6'h00, 32'h0);
    push(`CMD_DRSCAN, 6'h04, 32'h0000_000a);
    wait_rsp;
    wait_rsp;
    chk({config_ok, config_fail}, 32'h2, "ok verdict");
    chk(ceo_n, 0, "next device enabled");
    chk(chain_enable_in_n, 0, "chain enable low");
    chk(trst_n, 1, "test reset released");
  endtask
  task t_wait;
    int i;
    int n;
    logic pt;
    logic bad;
    n = 0;
    pt = tck;
    bad = 1'b0;
    push(`CMD_WAIT, 6'h00, 32'h3);
    for (i = 0; i < 3000 && rsp_valid !== 1'b1; i++) begin
      @(negedge clk);
      if (tck === 1'b1 && pt === 1'b0) n++;
      pt = tck;
      if (dev.state !== `TAP_IDLE) bad = 1'b1;
    end
    chk(n, 3, "idle clocks");
    chk(bad, 0, "left idle");
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_ir;
    t_fill;
    t_ok;
    t_wait;
    wrap_up;
  end
endmodule // jtag_config_chain_sequencer_bench
`default_nettype wire
